/* File: common/rtcc_pkg.sv */
// constants and types shared by the rtc control, interrupt and status block
package rtcc_pkg;
	// register indices on the multiplexed bus
	localparam logic [7:0] REG_CTRL  = 8'h0b;
	localparam logic [7:0] REG_FLAGS = 8'h0c;
	localparam logic [7:0] REG_VALID = 8'h0d;

	// control_settings fields
	localparam int CTL_FREEZE = 7;
	localparam int CTL_PIE    = 6;
	localparam int CTL_AIE    = 5;
	localparam int CTL_UIE    = 4;
	localparam int CTL_SQUARE_WAVE_ENABLE   = 3;
	localparam int CTL_DM     = 2;
	localparam int CTL_H24    = 1;
	localparam int CTL_DSE    = 0;

	// interrupt_flags fields
	localparam int FLG_ANY = 7;
	localparam int FLG_PF  = 6;
	localparam int FLG_AF  = 5;
	localparam int FLG_UF  = 4;
	localparam logic [3:0] FLG_LOW_ZERO = 4'h0;

	// ram_time_validity fields
	localparam logic [6:0] VAL_LOW_ZERO = 7'h00;

	localparam logic [1:0] ALARM_ANY = 2'h3;
	localparam logic [3:0] RATE_OFF  = 4'h0;

	// divider chain: stage 0 toggles at 32.768 kHz, top stage at 1 Hz
	localparam int DIV_W   = 16;
	localparam int SEC_TAP = 15;
	localparam int PRE_W   = 11;
	localparam int CNT_W   = 15;

	localparam int CLK_PERIOD_NS = 10;
	localparam int T_BUC_NS      = 244000;
	localparam int T_UC_NS       = 248000;
	localparam int T_TAP_NS      = 15259;
	localparam int BUC_CYC       = (T_BUC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UC_CYC        = T_UC_NS / CLK_PERIOD_NS;
	localparam int TAP_CYC       = T_TAP_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		UPD_IDLE = 2'b00,
		UPD_WAIT = 2'b01,
		UPD_RUN  = 2'b10
	} rtcc_upd_state_t;
endpackage

/* File: rtl/rtcc_rate_gen.sv */
// divider chain, periodic tap select and one-second tick
`timescale 1ns/10ps
module rtcc_rate_gen (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic [3:0] rate_select,
	output logic            periodic_tick,
	output logic            tap_level,
	output logic            second_tick
);
	logic [rtcc_pkg::PRE_W-1:0] pre_q;
	logic [rtcc_pkg::DIV_W-1:0] div_q;
	logic                       tap_q;
	logic                       sec_q;

	function automatic logic tap_sel(input logic [3:0] rs, input logic [rtcc_pkg::DIV_W-1:0] d);
		if (rs == rtcc_pkg::RATE_OFF)
			return 1'b0;
		return d[rs - 4'h1];
	endfunction

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q <= '0;
			div_q <= '0;
		end else if (clk_en) begin
			if (pre_q == rtcc_pkg::PRE_W'(rtcc_pkg::TAP_CYC - 1)) begin
				pre_q <= '0;
				div_q <= div_q + 1'b1;
			end else begin
				pre_q <= pre_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tap_q <= 1'b0;
			sec_q <= 1'b0;
		end else if (clk_en) begin
			tap_q <= tap_sel(rate_select, div_q);
			sec_q <= div_q[rtcc_pkg::SEC_TAP];
		end
	end

	assign tap_level     = tap_q;
	// rising edge of the chosen tap marks a period
	assign periodic_tick = clk_en & ~tap_q & tap_sel(rate_select, div_q);
	assign second_tick   = clk_en & ~sec_q & div_q[rtcc_pkg::SEC_TAP];
endmodule

/* File: rtl/rtcc_upd_seq.sv */
// once-per-second update sequencer: lead-in, update cycle, end pulse
`timescale 1ns/10ps
module rtcc_upd_seq #(
	parameter int BUC_CYCLES = rtcc_pkg::BUC_CYC,
	parameter int UC_CYCLES  = rtcc_pkg::UC_CYC
) (
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic clk_en,
	input  wire logic second_tick,
	input  wire logic freeze,
	output logic      update_pending,
	output logic      update_active,
	output logic      update_start,
	output logic      update_ended
);
	rtcc_pkg::rtcc_upd_state_t  state_q;
	logic [rtcc_pkg::CNT_W-1:0] cnt_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= rtcc_pkg::UPD_IDLE;
			cnt_q   <= '0;
		end else if (clk_en) begin
			if (freeze) begin
				state_q <= rtcc_pkg::UPD_IDLE;
				cnt_q   <= '0;
			end else begin
				case (state_q)
					rtcc_pkg::UPD_IDLE: begin
						if (second_tick) begin
							state_q <= rtcc_pkg::UPD_WAIT;
							cnt_q   <= rtcc_pkg::CNT_W'(BUC_CYCLES - 1);
						end
					end
					rtcc_pkg::UPD_WAIT: begin
						if (cnt_q == '0) begin
							state_q <= rtcc_pkg::UPD_RUN;
							cnt_q   <= rtcc_pkg::CNT_W'(UC_CYCLES - 1);
						end else begin
							cnt_q <= cnt_q - 1'b1;
						end
					end
					rtcc_pkg::UPD_RUN: begin
						if (cnt_q == '0)
							state_q <= rtcc_pkg::UPD_IDLE;
						else
							cnt_q <= cnt_q - 1'b1;
					end
					default: state_q <= rtcc_pkg::UPD_IDLE;
				endcase
			end
		end
	end

	assign update_pending = state_q != rtcc_pkg::UPD_IDLE;
	assign update_active  = state_q == rtcc_pkg::UPD_RUN;
	assign update_start   = clk_en & ~freeze & (state_q == rtcc_pkg::UPD_WAIT) & (cnt_q == '0);
	assign update_ended   = clk_en & ~freeze & (state_q == rtcc_pkg::UPD_RUN) & (cnt_q == '0);
endmodule

/* File: rtl/rtcc_core.sv */
// rtc control settings, interrupt flags, validity bit and bus port
`timescale 1ns/10ps
// What this block does
// - freeze stops and blocks once-per-second updates
// - periodic enable gates periodic flag onto irq
// - periodic enable changed only by software, reset
// - alarm flag on match, 11xxxxxx matches anything
// - alarm enable gates alarm flag, reset clears
// - update enable cleared by reset or freeze
// - square wave follows rate, low when disabled
// - binary format bit, software only, no reset
// - 24-hour bit, software only
// - april last sunday: 1:59:59 jumps to 3:00:00
// - october: first 1:59:59 returns to 1:00:00
// - flag register read-only, low nibble zero
// - any flag is or of enabled flags
// - irq driven low while any flag set
// - flags clear on read and in reset
// - periodic flag set on tap edge always
// - update flag set at each update end
// - validity bit zero while power sense low
// - validity bit set only by reading it
// - validity low bits read zero, unwritable
// - rate zero disables, codes double the period
// - pending rises 244 us before update
// - update cycle lasts 248 us
module rtcc_core #(
	parameter int BUC_CYCLES = rtcc_pkg::BUC_CYC,
	parameter int UC_CYCLES  = rtcc_pkg::UC_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic [7:0] ad_in,
	output logic      [7:0] ad_out,
	output logic            ad_oe_n,
	input  wire logic       address_strobe,
	input  wire logic       data_strobe,
	input  wire logic       read_write,
	input  wire logic       chip_enable_n,
	output logic            interrupt_request_out,
	output logic            interrupt_request_oe_n,
	input  wire logic       power_sense_in,
	output logic            ram_time_valid,
	input  wire logic [3:0] rate_select,
	output logic            square_wave_out,
	input  wire logic [7:0] cur_seconds,
	input  wire logic [7:0] cur_minutes,
	input  wire logic [7:0] cur_hours,
	input  wire logic [7:0] alarm_seconds,
	input  wire logic [7:0] alarm_minutes,
	input  wire logic [7:0] alarm_hours,
	input  wire logic       spring_day_in,
	input  wire logic       fall_day_in,
	input  wire logic       at_015959_am_in,
	output logic            freeze_updates,
	output logic            data_format_binary,
	output logic            hour_format_24,
	output logic            summer_time_enable,
	output logic            update_pending,
	output logic            update_active,
	output logic            update_start,
	output logic            dst_jump_forward,
	output logic            dst_jump_back
);
	logic       as_q;
	logic       ds_q;
	logic [7:0] addr_q;
	logic [7:0] rdata_q;
	logic       drive_q;
	logic       freeze_q;
	logic       pie_q;
	logic       aie_q;
	logic       uie_q;
	logic       square_wave_enable_q;
	logic       dm_q;
	logic       h24_q;
	logic       dse_q;
	logic       pf_q;
	logic       af_q;
	logic       uf_q;
	logic       vrt_q;
	logic       sqw_q;
	logic       fwd_q;
	logic       back_q;
	logic       fall_done_q;
	logic       periodic_tick;
	logic       tap_level;
	logic       second_tick;
	logic       update_ended;
	logic       ds_rise;
	logic       ds_fall;
	logic       rd_start;
	logic       rd_flags;
	logic       rd_valid;
	logic       ctrl_wr;
	logic       alarm_hit;
	logic       any_flag;
	logic [7:0] ctrl_view;
	logic [7:0] flags_view;
	logic [7:0] valid_view;

	function automatic logic reg_hit(input logic [7:0] a);
		return (a == rtcc_pkg::REG_CTRL) || (a == rtcc_pkg::REG_FLAGS) || (a == rtcc_pkg::REG_VALID);
	endfunction

	function automatic logic alarm_match(input logic [7:0] alm, input logic [7:0] cur);
		return (alm[7:6] == rtcc_pkg::ALARM_ANY) || (alm == cur);
	endfunction

	rtcc_rate_gen u_rate (
		.core_clk      (core_clk),
		.reset_n       (reset_n),
		.clk_en        (clk_en),
		.rate_select   (rate_select),
		.periodic_tick (periodic_tick),
		.tap_level     (tap_level),
		.second_tick   (second_tick)
	);

	rtcc_upd_seq #(
		.BUC_CYCLES (BUC_CYCLES),
		.UC_CYCLES  (UC_CYCLES)
	) u_seq (
		.core_clk       (core_clk),
		.reset_n        (reset_n),
		.clk_en         (clk_en),
		.second_tick    (second_tick),
		.freeze         (freeze_q),
		.update_pending (update_pending),
		.update_active  (update_active),
		.update_start   (update_start),
		.update_ended   (update_ended)
	);

	// bus strobes are sampled synchronously; edges found against last sample
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			as_q <= 1'b0;
			ds_q <= 1'b0;
		end else if (clk_en) begin
			as_q <= address_strobe;
			ds_q <= data_strobe;
		end
	end

	// register index latched as address strobe falls
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			addr_q <= '0;
		else if (clk_en && as_q && !address_strobe)
			addr_q <= ad_in;
	end

	assign ds_rise  = clk_en & ~ds_q & data_strobe;
	assign ds_fall  = clk_en & ds_q & ~data_strobe;
	assign rd_start = ds_rise & read_write & ~chip_enable_n & reg_hit(addr_q);
	assign rd_flags = rd_start & (addr_q == rtcc_pkg::REG_FLAGS);
	assign rd_valid = rd_start & (addr_q == rtcc_pkg::REG_VALID);
	assign ctrl_wr  = ds_fall & ~read_write & ~chip_enable_n & (addr_q == rtcc_pkg::REG_CTRL);

	always_comb begin
		ctrl_view = '0;
		ctrl_view[rtcc_pkg::CTL_FREEZE] = freeze_q;
		ctrl_view[rtcc_pkg::CTL_PIE]    = pie_q;
		ctrl_view[rtcc_pkg::CTL_AIE]    = aie_q;
		ctrl_view[rtcc_pkg::CTL_UIE]    = uie_q;
		ctrl_view[rtcc_pkg::CTL_SQUARE_WAVE_ENABLE]   = square_wave_enable_q;
		ctrl_view[rtcc_pkg::CTL_DM]     = dm_q;
		ctrl_view[rtcc_pkg::CTL_H24]    = h24_q;
		ctrl_view[rtcc_pkg::CTL_DSE]    = dse_q;
	end

	assign any_flag   = (pf_q & pie_q) | (af_q & aie_q) | (uf_q & uie_q);
	assign flags_view = {any_flag, pf_q, af_q, uf_q, rtcc_pkg::FLG_LOW_ZERO};
	assign valid_view = {ram_time_valid, rtcc_pkg::VAL_LOW_ZERO};

	// read data captured at strobe rise and held until it falls
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= '0;
			drive_q <= 1'b0;
		end else if (rd_start) begin
			drive_q <= 1'b1;
			case (addr_q)
				rtcc_pkg::REG_CTRL:  rdata_q <= ctrl_view;
				rtcc_pkg::REG_FLAGS: rdata_q <= flags_view;
				rtcc_pkg::REG_VALID: rdata_q <= valid_view;
				default:             rdata_q <= '0;
			endcase
		end else if (ds_fall) begin
			drive_q <= 1'b0;
		end
	end

	assign ad_out  = rdata_q;
	assign ad_oe_n = ~drive_q;

	// enables that reset clears; nothing inside the block touches them
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			freeze_q <= 1'b0;
			pie_q    <= 1'b0;
			aie_q    <= 1'b0;
			uie_q    <= 1'b0;
			square_wave_enable_q   <= 1'b0;
		end else if (ctrl_wr) begin
			freeze_q <= ad_in[rtcc_pkg::CTL_FREEZE];
			pie_q    <= ad_in[rtcc_pkg::CTL_PIE];
			aie_q    <= ad_in[rtcc_pkg::CTL_AIE];
			uie_q    <= ad_in[rtcc_pkg::CTL_UIE] & ~ad_in[rtcc_pkg::CTL_FREEZE];
			square_wave_enable_q   <= ad_in[rtcc_pkg::CTL_SQUARE_WAVE_ENABLE];
		end
	end

	// format bits survive reset on purpose: they describe the stored time
	always_ff @(posedge core_clk) begin
		if (ctrl_wr) begin
			dm_q  <= ad_in[rtcc_pkg::CTL_DM];
			h24_q <= ad_in[rtcc_pkg::CTL_H24];
			dse_q <= ad_in[rtcc_pkg::CTL_DSE];
		end
	end

	assign freeze_updates     = freeze_q;
	assign data_format_binary = dm_q;
	assign hour_format_24     = h24_q;
	assign summer_time_enable = dse_q;

	assign alarm_hit = alarm_match(alarm_hours, cur_hours) & alarm_match(alarm_minutes, cur_minutes) &
		alarm_match(alarm_seconds, cur_seconds);

	// set beats the read clear so an event in the read cycle is kept
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pf_q <= 1'b0;
			af_q <= 1'b0;
			uf_q <= 1'b0;
		end else if (clk_en) begin
			pf_q <= (pf_q & ~rd_flags) | periodic_tick;
			af_q <= (af_q & ~rd_flags) | (update_ended & alarm_hit);
			uf_q <= (uf_q & ~rd_flags) | update_ended;
		end
	end

	// open drain: only ever pulls low
	assign interrupt_request_out  = 1'b0;
	assign interrupt_request_oe_n = ~any_flag;

	// power sense forces the bit regardless of reset or clock enable
	always_ff @(posedge core_clk) begin
		if (!power_sense_in)
			vrt_q <= 1'b0;
		else if (rd_valid)
			vrt_q <= 1'b1;
	end

	assign ram_time_valid = vrt_q & power_sense_in;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			sqw_q <= 1'b0;
		else if (clk_en)
			sqw_q <= square_wave_enable_q & tap_level;
	end

	assign square_wave_out = sqw_q;

	// clock changes are issued at the start of the update at 1:59:59 am
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fwd_q       <= 1'b0;
			back_q      <= 1'b0;
			fall_done_q <= 1'b0;
		end else if (clk_en) begin
			fwd_q  <= update_start & dse_q & spring_day_in & at_015959_am_in;
			back_q <= update_start & dse_q & fall_day_in & at_015959_am_in & ~fall_done_q;
			if (!fall_day_in)
				fall_done_q <= 1'b0;
			else if (update_start && dse_q && at_015959_am_in)
				fall_done_q <= 1'b1;
		end
	end

	assign dst_jump_forward = fwd_q;
	assign dst_jump_back    = back_q;

	sequence s_read_flags;
		rd_flags && !periodic_tick && !update_ended;
	endsequence

	sequence s_update_begins;
		$rose(update_active);
	endsequence

	property p_irq_level;
		@(posedge core_clk) disable iff (!reset_n)
		interrupt_request_oe_n == !((pf_q && pie_q) || (af_q && aie_q) || (uf_q && uie_q));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq pin disagrees with enabled flags");

	property p_pf_set;
		@(posedge core_clk) disable iff (!reset_n)
		periodic_tick |=> flags_view[rtcc_pkg::FLG_PF];
	endproperty
	a_pf_set: assert property (p_pf_set) else $error("periodic flag not set on tap edge");

	property p_uf_set;
		@(posedge core_clk) disable iff (!reset_n)
		update_ended |=> uf_q && !update_active;
	endproperty
	a_uf_set: assert property (p_uf_set) else $error("update flag not set at update end");

	property p_read_clears;
		@(posedge core_clk) disable iff (!reset_n)
		s_read_flags |=> !pf_q && !af_q && !uf_q && !any_flag;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flags not cleared by read");

	property p_freeze_uie;
		@(posedge core_clk) disable iff (!reset_n)
		ctrl_wr && ad_in[rtcc_pkg::CTL_FREEZE] |=> !uie_q && freeze_q;
	endproperty
	a_freeze_uie: assert property (p_freeze_uie) else $error("freeze left update enable set");

	property p_freeze_abort;
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && freeze_q |=> !update_pending && !update_active;
	endproperty
	a_freeze_abort: assert property (p_freeze_abort) else $error("update ran while frozen");

	property p_vrt_sense;
		@(posedge core_clk) disable iff (!reset_n)
		!power_sense_in |-> !ram_time_valid ##1 (power_sense_in || !vrt_q);
	endproperty
	a_vrt_sense: assert property (p_vrt_sense) else $error("validity bit set without power sense");

	property p_vrt_read;
		@(posedge core_clk) disable iff (!reset_n)
		rd_valid && power_sense_in ##1 power_sense_in |-> ram_time_valid;
	endproperty
	a_vrt_read: assert property (p_vrt_read) else $error("validity read did not set bit");

	property p_sqw_off;
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && !square_wave_enable_q |=> !square_wave_out;
	endproperty
	a_sqw_off: assert property (p_sqw_off) else $error("square wave active while disabled");

	property p_lead_in;
		@(posedge core_clk) disable iff (!reset_n)
		s_update_begins |-> $past(update_pending) && $past(update_start);
	endproperty
	a_lead_in: assert property (p_lead_in) else $error("update began without pending lead-in");

	property p_low_zero;
		@(posedge core_clk) disable iff (!reset_n)
		!drive_q ##1 drive_q && addr_q != rtcc_pkg::REG_CTRL |-> ad_out[3:0] == 4'h0;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("unused status bits read nonzero");
endmodule

/* File: tb/rtcc_host_model.sv */
// microprocessor model driving the multiplexed address/data bus with strobes
`timescale 1ns/10ps
module rtcc_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] ad_out,
	input  wire logic       ad_oe_n,
	output logic      [7:0] ad_in,
	output logic            address_strobe,
	output logic            data_strobe,
	output logic            read_write,
	output logic            chip_enable_n
);
	logic [7:0] drv_q    = 8'h00;
	logic       drv_en_q = 1'b0;
	logic [7:0] last_q   = 8'h00;

	initial begin
		address_strobe = 1'b0;
		data_strobe = 1'b0;
		read_write = 1'b1;
		chip_enable_n = 1'b1;
	end

	// undriven bus flips every cycle so stale data never looks valid
	always @(posedge core_clk) begin
		last_q <= ad_in;
	end
	assign ad_in = !ad_oe_n ? ad_out : (drv_en_q ? drv_q : ~last_q);

	task automatic addr_phase(input logic [7:0] a);
		@(posedge core_clk);
		drv_q <= a;
		drv_en_q <= 1'b1;
		address_strobe <= 1'b1;
		@(posedge core_clk);
		address_strobe <= 1'b0;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		addr_phase(a);
		@(posedge core_clk);
		read_write <= 1'b0;
		chip_enable_n <= 1'b0;
		drv_q <= d;
		data_strobe <= 1'b1;
		repeat (2) @(posedge core_clk);
		data_strobe <= 1'b0;
		@(posedge core_clk);
		chip_enable_n <= 1'b1;
		drv_en_q <= 1'b0;
		@(posedge core_clk);
	endtask

	// data taken while strobe still high, after the device turned the bus round
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		addr_phase(a);
		@(posedge core_clk);
		read_write <= 1'b1;
		chip_enable_n <= 1'b0;
		drv_en_q <= 1'b0;
		data_strobe <= 1'b1;
		repeat (3) @(posedge core_clk);
		d = ad_in;
		data_strobe <= 1'b0;
		repeat (2) @(posedge core_clk);
		chip_enable_n <= 1'b1;
	endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the rtc control, interrupt and status block
`timescale 1ns/10ps
module testbench;
	localparam logic [7:0] FMT = (8'h01 << rtcc_pkg::CTL_DM) | (8'h01 << rtcc_pkg::CTL_H24) | (8'h01 << rtcc_pkg::CTL_DSE);
	localparam logic [7:0] SQUARE_WAVE_OUT = 8'h01 << rtcc_pkg::CTL_SQUARE_WAVE_ENABLE;
	localparam logic [7:0] PERIODIC_IRQ_ENABLE = 8'h01 << rtcc_pkg::CTL_PIE;
	localparam logic [7:0] ALARM_IRQ_ENABLE = 8'h01 << rtcc_pkg::CTL_AIE;
	localparam logic [7:0] UPDATE_DONE_IRQ_ENABLE = 8'h01 << rtcc_pkg::CTL_UIE;
	localparam logic [7:0] FRZ = 8'h01 << rtcc_pkg::CTL_FREEZE;
	localparam logic [7:0] PFB = 8'h01 << rtcc_pkg::FLG_PF;
	localparam logic [7:0] ANY = 8'h01 << rtcc_pkg::FLG_ANY;

	logic       core_clk       = 1'b0;
	logic       reset_n        = 1'b0;
	logic       clk_en         = 1'b1;
	logic       power_sense_in = 1'b1;
	logic [3:0] rate_select    = 4'h0;
	logic [7:0] cur_time       = 8'h00;
	logic [7:0] alarm_byte     = 8'hc0;
	logic       day_flag       = 1'b0;
	logic [7:0] ad_in;
	logic [7:0] ad_out;
	logic       ad_oe_n;
	logic       address_strobe;
	logic       data_strobe;
	logic       read_write;
	logic       chip_enable_n;
	logic       interrupt_request_oe_n;
	logic       interrupt_request_out;
	logic       update_pending;
	logic       ram_time_valid;
	logic       square_wave_out;
	logic       freeze_updates;
	logic       data_format_binary;
	logic       hour_format_24;
	logic       summer_time_enable;
	int         num_errors   = 0;
	int         total_checks = 0;

	always #5 core_clk = ~core_clk;

	rtcc_host_model u_rtcc_host_model (
		.core_clk       (core_clk),
		.ad_out         (ad_out),
		.ad_oe_n        (ad_oe_n),
		.ad_in          (ad_in),
		.address_strobe (address_strobe),
		.data_strobe    (data_strobe),
		.read_write     (read_write),
		.chip_enable_n  (chip_enable_n)
	);

	rtcc_core #(.BUC_CYCLES(20), .UC_CYCLES(20)) u_rtcc_core (
		.core_clk               (core_clk),
		.reset_n                (reset_n),
		.clk_en                 (clk_en),
		.ad_in                  (ad_in),
		.ad_out                 (ad_out),
		.ad_oe_n                (ad_oe_n),
		.address_strobe         (address_strobe),
		.data_strobe            (data_strobe),
		.read_write             (read_write),
		.chip_enable_n          (chip_enable_n),
		.interrupt_request_out  (interrupt_request_out),
		.interrupt_request_oe_n (interrupt_request_oe_n),
		.power_sense_in         (power_sense_in),
		.ram_time_valid         (ram_time_valid),
		.rate_select            (rate_select),
		.square_wave_out        (square_wave_out),
		.cur_seconds            (cur_time),
		.cur_minutes            (cur_time),
		.cur_hours              (cur_time),
		.alarm_seconds          (alarm_byte),
		.alarm_minutes          (alarm_byte),
		.alarm_hours            (alarm_byte),
		.spring_day_in          (day_flag),
		.fall_day_in            (day_flag),
		.at_015959_am_in        (day_flag),
		.freeze_updates         (freeze_updates),
		.data_format_binary     (data_format_binary),
		.hour_format_24         (hour_format_24),
		.summer_time_enable     (summer_time_enable),
		.update_pending         (update_pending),
		.update_active          (),
		.update_start           (),
		.dst_jump_forward       (),
		.dst_jump_back          ()
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		if (num_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_rtcc_host_model.reg_read(a, d);
		check(d, exp);
	endtask

	// counts square wave rises and high cycles over a window
	task automatic watch_sqw(input int cycles, output int rises, output int highs);
		logic prev;
		rises = 0;
		highs = 0;
		prev = square_wave_out;
		repeat (cycles) begin
			@(posedge core_clk);
			if (square_wave_out === 1'b1 && prev !== 1'b1) rises++;
			if (square_wave_out !== 1'b0) highs++;
			prev = square_wave_out;
		end
	endtask

	initial begin
		#800000;
		num_errors++;
		final_report();
	end

	initial begin
		logic [7:0] d;
		int n;
		int h;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		check({7'h00, interrupt_request_oe_n}, 8'h01);
		check({7'h00, square_wave_out}, 8'h00);
		rd_check(rtcc_pkg::REG_FLAGS, 8'h00);
		u_rtcc_host_model.reg_read(rtcc_pkg::REG_VALID, d);
		rd_check(rtcc_pkg::REG_VALID, 8'h80);
		u_rtcc_host_model.reg_write(rtcc_pkg::REG_VALID, 8'h00);
		rd_check(rtcc_pkg::REG_VALID, 8'h80);
		power_sense_in <= 1'b0;
		repeat (3) @(posedge core_clk);
		check({7'h00, ram_time_valid}, 8'h00);
		power_sense_in <= 1'b1;
		repeat (3) @(posedge core_clk);
		check({7'h00, ram_time_valid}, 8'h00);
		rd_check(rtcc_pkg::REG_VALID, 8'h00);
		rd_check(rtcc_pkg::REG_VALID, 8'h80);
		// format bits and square wave, periodic source still off
		u_rtcc_host_model.reg_write(rtcc_pkg::REG_CTRL, FMT | SQUARE_WAVE_OUT);
		rd_check(rtcc_pkg::REG_CTRL, FMT | SQUARE_WAVE_OUT);
		check({4'h0, freeze_updates, data_format_binary, hour_format_24, summer_time_enable}, 8'h07);
		u_rtcc_host_model.reg_write(rtcc_pkg::REG_FLAGS, 8'hff);
		watch_sqw(5000, n, h);
		check({7'h00, h != 0}, 8'h00);
		rd_check(rtcc_pkg::REG_FLAGS, 8'h00);
		// rate 1 starts the periodic tap: square wave must rise at least twice
		rate_select <= 4'h1;
		watch_sqw(7000, n, h);
		check({7'h00, n >= 2}, 8'h01);
		// clock enable low must freeze the divider and the pin
		clk_en <= 1'b0;
		@(posedge core_clk);
		watch_sqw(4000, n, h);
		clk_en <= 1'b1;
		check({7'h00, n == 0 && (h == 0 || h == 4000)}, 8'h01);
		check({7'h00, interrupt_request_oe_n}, 8'h01);
		rd_check(rtcc_pkg::REG_FLAGS, PFB);
		u_rtcc_host_model.reg_write(rtcc_pkg::REG_CTRL, FMT | SQUARE_WAVE_OUT | PERIODIC_IRQ_ENABLE);
		n = 0;
		while (interrupt_request_oe_n !== 1'b0 && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		check({6'h00, interrupt_request_oe_n, interrupt_request_out}, 8'h00);
		rd_check(rtcc_pkg::REG_FLAGS, ANY | PFB);
		repeat (2) @(posedge core_clk);
		check({7'h00, interrupt_request_oe_n}, 8'h01);
		// square wave held low when disabled
		u_rtcc_host_model.reg_write(rtcc_pkg::REG_CTRL, FMT);
		watch_sqw(7000, n, h);
		check({7'h00, h != 0}, 8'h00);
		// freeze drops the update-ended enable
		u_rtcc_host_model.reg_write(rtcc_pkg::REG_CTRL, FMT | FRZ | UPDATE_DONE_IRQ_ENABLE | ALARM_IRQ_ENABLE);
		rd_check(rtcc_pkg::REG_CTRL, FMT | FRZ | ALARM_IRQ_ENABLE);
		check({7'h00, freeze_updates}, 8'h01);
		check({7'h00, update_pending}, 8'h00);
		// reset clears enables, keeps format bits and validity
		u_rtcc_host_model.reg_write(rtcc_pkg::REG_CTRL, FMT | PERIODIC_IRQ_ENABLE | ALARM_IRQ_ENABLE | SQUARE_WAVE_OUT);
		rate_select <= 4'h0;
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd_check(rtcc_pkg::REG_CTRL, FMT);
		rd_check(rtcc_pkg::REG_VALID, 8'h80);
		rd_check(rtcc_pkg::REG_FLAGS, 8'h00);
		final_report();
	end
endmodule
